// [cfl_loader.sv]
// Configuration loader: fills the configuration memory cells from a bitstream.
// Assumes all pins except reset_n_i are asynchronous to clk_sys_i; security engine inputs are on clk_sys_i.
`timescale 1ns/1ns

module cfl_loader
  import cfl_pkg::*;
#(
  parameter int WAKE_CYC = WAKE_WAIT_CYC
) (
  input wire logic clk_sys_i, // System clock, 250 MHz.
  input wire logic reset_n_i, // Synchronous reset, active low.
  input wire logic config_reset_n_i, // Configuration reset pin, active low.
  input wire logic [1:0] mode_sel_i, // Mode strap.
  input wire logic [2:0] width_sel_i, // Width strap: 0..5 = X1..X32.
  input wire logic addr4_i, // Strap: four-byte flash addressing.
  input wire logic clk_src_ext_i, // Strap: active clock from external pin.
  input wire logic external_config_clock_pin_i, // External configuration clock.
  input wire logic [7:0] flash_io_i, // Flash data lines in.
  output logic flash_sclk_o, // Flash serial clock.
  output logic flash_cs_n_o, // Flash select, active low.
  output logic [7:0] flash_io_o, // Flash data lines out.
  output logic [7:0] flash_io_oe_o, // Flash data output enables.
  input wire logic pas_clk_i, // Passive master clock.
  input wire logic pas_cs_n_i, // Passive select, active low.
  input wire logic [15:0] pas_data_i, // Passive data lines.
  input wire logic jtag_tck_i, // Boundary-scan clock.
  input wire logic jtag_tdi_i, // Boundary-scan data in.
  input wire logic security_en_i, // Bitstream security enabled.
  input wire logic auth_fail_i, // Signature check failed.
  output logic config_memory_cells_we_o, // Configuration memory write strobe.
  output logic [15:0] config_memory_cells_addr_o, // Configuration memory word address.
  output logic [15:0] config_memory_cells_data_o, // Configuration memory word.
  output logic busy_o, // Loading in progress.
  output logic user_mode_o, // Device in user mode.
  output logic error_o // Loading refused or aborted.
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [SYNC_W-1:0] pin_meta;
  logic [SYNC_W-1:0] pin_sync;
  logic cr_prev;
  logic ext_prev;
  logic pas_prev;
  logic tck_prev;

  wire [SYNC_W-1:0] pin_raw = {config_reset_n_i, external_config_clock_pin_i, pas_clk_i, pas_cs_n_i,
    jtag_tck_i, jtag_tdi_i, mode_sel_i, width_sel_i, addr4_i, clk_src_ext_i, flash_io_i, pas_data_i};

  always_ff @(posedge clk_sys_i) begin
    pin_meta <= pin_raw;
    pin_sync <= pin_meta;
    cr_prev <= pin_sync[36];
    ext_prev <= pin_sync[35];
    pas_prev <= pin_sync[34];
    tck_prev <= pin_sync[32];
  end

  wire cr_n = pin_sync[36];
  wire ext_rise = pin_sync[35] & ~ext_prev;
  wire pas_rise = pin_sync[34] & ~pas_prev;
  wire pas_sel = ~pin_sync[33];
  wire tck_rise = pin_sync[32] & ~tck_prev;
  wire tdi = pin_sync[31];
  wire [1:0] mode_pin = pin_sync[30:29];
  wire [2:0] width_pin = pin_sync[28:26];
  wire addr4_pin = pin_sync[25];
  wire ext_pin = pin_sync[24];
  wire [7:0] flash_in = pin_sync[23:16];
  wire [15:0] pas_in = pin_sync[15:0];
  wire cr_rise = cr_n & ~cr_prev;

  // ****************************************
  // State and datapath registers
  // ****************************************
  cfl_state_t state;
  cfl_state_t next_state;
  logic [1:0] mode;
  logic [2:0] width;
  logic addr4;
  logic clk_ext;
  logic [7:0] osc_cnt;
  logic sclk;
  logic [47:0] tx_shift;
  logic [5:0] tx_left;
  logic [15:0] wait_cnt;
  logic [15:0] acc;
  logic [4:0] acc_bits;
  logic [15:0] word_cnt;

  // internal oscillator as a divided enable, or edges of the external pin
  wire osc_tick = (osc_cnt == OSC_DIV - 8'h01);
  wire cfg_tick = clk_ext ? ext_rise : osc_tick;
  wire sclk_rise = cfg_tick & ~sclk;
  wire sclk_fall = cfg_tick & sclk;

  // legal widths per mode
  // Mode codes 2 and 3 both select boundary-scan loading, so only the upper strap bit is decoded.
  wire width_ok = (width_pin <= WID_X8) | ((mode_pin == MODE_PASSIVE) & (width_pin == WID_X16)
    & ~security_en_i) | mode_pin[1];
  wire [4:0] step = mode[1] ? 5'h01 : 5'((5'h01) << width);

  // Bits gathered this cycle, right aligned.
  wire [15:0] in_bits = mode[1] ? {15'h0000, tdi} :
    (mode == MODE_PASSIVE) ? pas_in : {8'h00, flash_in};
  wire [15:0] in_mask = 16'((17'h00001 << step) - 17'h00001);
  wire take = (state == CFL_DATA & sclk_rise) | (state == CFL_PASSIVE & pas_rise & pas_sel)
    | (state == CFL_JTAG & tck_rise);
  wire [4:0] acc_next_bits = acc_bits + step;
  wire word_full = take & (acc_next_bits == WORD_BITS);
  wire last_word = word_full & (word_cnt == LOAD_WORDS - 16'h0001);
  wire [5:0] read_bits = addr4 ? READ4_BITS : READ3_BITS;
  wire [47:0] read_seq = addr4 ? {CMD_FAST_READ, START_ADDR, DUMMY_BYTE}
    : {CMD_FAST_READ, START_ADDR[23:0], DUMMY_BYTE, 8'h00};

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    next_state = state;
    unique case (state)
      CFL_IDLE: begin
        // mode chosen from straps at reset release
        if (cr_rise & ~width_ok) begin
          next_state = CFL_FAIL;
        end else if (cr_rise & mode_pin == MODE_ACTIVE) begin
          next_state = CFL_WAKE;
        end else if (cr_rise & mode_pin == MODE_PASSIVE) begin
          next_state = CFL_PASSIVE;
        end else if (cr_rise) begin
          next_state = CFL_JTAG;
        end
      end
      CFL_WAKE: begin
        // Leaving on the falling edge keeps the last rise visible on the flash clock.
        if (sclk_fall & tx_left == 6'h01) begin
          next_state = CFL_GAP;
        end
      end
      CFL_GAP: begin
        if (wait_cnt == 16'(WAKE_CYC - 1) & sclk_fall) begin
          next_state = CFL_CMD;
        end
      end
      CFL_CMD: begin
        if (sclk_fall & tx_left == 6'h01) begin
          next_state = CFL_DATA;
        end
      end
      CFL_DATA, CFL_PASSIVE, CFL_JTAG: begin
        if (last_word) begin
          next_state = CFL_DONE;
        end
      end
      CFL_DONE, CFL_FAIL: begin
        next_state = state;
      end
    endcase
    if (auth_fail_i & state != CFL_IDLE & state != CFL_FAIL) begin
      next_state = CFL_FAIL;
    end
    // held while config reset is low
    if (~cr_n) begin
      next_state = CFL_IDLE;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      state <= CFL_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i || state == CFL_IDLE) begin
      osc_cnt <= 8'h00;
      sclk <= 1'b0;
    end else begin
      osc_cnt <= osc_tick ? 8'h00 : osc_cnt + 8'h01;
      if (cfg_tick) begin
        sclk <= ~sclk;
      end
    end
  end

  // Straps are caught on the release edge so they cannot change mid-load.
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      mode <= MODE_ACTIVE;
      width <= 3'h0;
      addr4 <= 1'b0;
      clk_ext <= 1'b0;
    end else if (state == CFL_IDLE & cr_rise) begin
      mode <= mode_pin;
      width <= mode_pin[1] ? 3'h0 : width_pin;
      addr4 <= addr4_pin;
      clk_ext <= ext_pin;
    end
  end

  // ****************************************
  // Flash command shifter
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i || state == CFL_IDLE) begin
      tx_shift <= {CMD_WAKE, 40'h0000000000};
      tx_left <= WAKE_BITS;
      wait_cnt <= 16'h0000;
    end else if (state == CFL_GAP) begin
      // address zero, width by addressing mode
      tx_shift <= read_seq;
      tx_left <= read_bits;
      if (wait_cnt != 16'(WAKE_CYC - 1)) begin
        wait_cnt <= wait_cnt + 16'h0001;
      end
    end else if ((state == CFL_WAKE | state == CFL_CMD) & sclk_fall) begin
      // device shifts out its own command
      // The bit moves on the falling edge so it is settled at the rise that the flash samples.
      tx_shift <= {tx_shift[46:0], 1'b0};
      tx_left <= tx_left - 6'h01;
    end
  end

  // ****************************************
  // Word assembly into configuration memory
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i || state == CFL_IDLE) begin
      acc <= 16'h0000;
      acc_bits <= 5'h00;
      word_cnt <= 16'h0000;
      config_memory_cells_we_o <= 1'b0;
      config_memory_cells_addr_o <= 16'h0000;
      config_memory_cells_data_o <= 16'h0000;
    end else begin
      config_memory_cells_we_o <= word_full;
      if (take) begin
        acc <= 16'((acc << step) | (in_bits & in_mask));
        acc_bits <= word_full ? 5'h00 : acc_next_bits;
      end
      if (word_full) begin
        config_memory_cells_data_o <= 16'((acc << step) | (in_bits & in_mask));
        config_memory_cells_addr_o <= word_cnt;
        word_cnt <= word_cnt + 16'h0001;
      end
    end
  end

  // ****************************************
  // Pin and status outputs
  // ****************************************
  // the device masters the flash in active mode
  wire flash_active = (state == CFL_WAKE) | (state == CFL_CMD) | (state == CFL_DATA);
  assign flash_cs_n_o = ~flash_active;
  assign flash_sclk_o = sclk & flash_active;
  assign flash_io_o = {7'h00, tx_shift[47] & flash_active};
  assign flash_io_oe_o = {7'h00, (state == CFL_WAKE) | (state == CFL_CMD)};
  assign busy_o = (state != CFL_IDLE) & (state != CFL_DONE) & (state != CFL_FAIL);
  // user logic released only after a full load
  assign user_mode_o = (state == CFL_DONE);
  assign error_o = (state == CFL_FAIL);

endmodule : cfl_loader

// [cfl_pkg.sv]
// Constants and types shared by the configuration loader.
// Assumes a single 250 MHz system clock and pins sampled through synchronisers.
package cfl_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int WAKE_WAIT_NS = 30000;
  localparam int WAKE_WAIT_CYC = (WAKE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] OSC_DIV = 8'h04;

  // ****************************************
  // Flash sequence
  // ****************************************
  localparam logic [7:0] CMD_WAKE = 8'hab;
  localparam logic [7:0] CMD_FAST_READ = 8'h0b;
  localparam logic [31:0] START_ADDR = 32'h00000000;
  localparam logic [7:0] DUMMY_BYTE = 8'h00;
  localparam logic [5:0] WAKE_BITS = 6'h08;
  localparam logic [5:0] READ3_BITS = 6'h28;
  localparam logic [5:0] READ4_BITS = 6'h30;

  // ****************************************
  // Strap encodings and sizes
  // ****************************************
  localparam logic [1:0] MODE_ACTIVE = 2'h0;
  localparam logic [1:0] MODE_PASSIVE = 2'h1;
  localparam logic [1:0] MODE_JTAG = 2'h2;
  localparam logic [2:0] WID_X8 = 3'h3;
  localparam logic [2:0] WID_X16 = 3'h4;
  localparam logic [4:0] WORD_BITS = 5'h10;
  localparam logic [15:0] LOAD_WORDS = 16'h0400;
  localparam int SYNC_W = 37;

  typedef enum logic [3:0] {
    CFL_IDLE, CFL_WAKE, CFL_GAP, CFL_CMD, CFL_DATA, CFL_PASSIVE, CFL_JTAG, CFL_DONE, CFL_FAIL
  } cfl_state_t;

endpackage : cfl_pkg

// [cfl_loader_monitor.sv]
// Port checker for the configuration loader.
// Assumes it is bound to cfl_loader and sees its ports only.
`timescale 1ns/1ns
module cfl_loader_monitor
  import cfl_pkg::*;
#(
  parameter int WAKE_CYC = WAKE_WAIT_CYC
) (
  input wire logic clk_sys_i, // Clock.
  input wire logic reset_n_i, // Reset.
  input wire logic config_reset_n_i, // Config reset pin.
  input wire logic [1:0] mode_sel_i, // Mode strap.
  input wire logic [2:0] width_sel_i, // Width strap.
  input wire logic security_en_i, // Security on.
  input wire logic auth_fail_i, // Signature failure.
  input wire logic flash_cs_n_o, // Flash select.
  input wire logic [7:0] flash_io_oe_o, // Output enables.
  input wire logic config_memory_cells_we_o, // Word strobe.
  input wire logic busy_o, // Busy.
  input wire logic user_mode_o, // User mode.
  input wire logic error_o // Error.
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  logic [15:0] gap;
  logic woke;
  // Gap length after the wake frame closes.
  always_ff @(posedge clk_sys_i) begin
    gap <= (!reset_n_i || !flash_cs_n_o) ? 16'h0000 : gap + 16'h0001;
    woke <= reset_n_i && busy_o && (woke || (flash_cs_n_o && !$past(flash_cs_n_o)));
  end
  sequence s_rel;
    $rose(config_reset_n_i) && !auth_fail_i;
  endsequence
  property p_start; s_rel ##0 (mode_sel_i == MODE_ACTIVE && width_sel_i <= WID_X8) |-> ##[2:8] !flash_cs_n_o;
  endproperty
  property p_wide; s_rel ##0 (!mode_sel_i[1] && (width_sel_i == 3'h5 || (mode_sel_i == MODE_ACTIVE
    && width_sel_i == WID_X16))) |-> ##[2:8] error_o; endproperty
  property p_sec; s_rel ##0 (mode_sel_i == MODE_PASSIVE && width_sel_i == WID_X16 && security_en_i)
    |-> ##[2:8] error_o; endproperty
  property p_hold; !config_reset_n_i [*6] |=> flash_cs_n_o && !config_memory_cells_we_o; endproperty
  property p_gap; $fell(flash_cs_n_o) && woke |-> gap >= WAKE_CYC; endproperty
  property p_auth; auth_fail_i && busy_o |-> ##[1:4] error_o; endproperty
  property p_err; error_o |-> flash_cs_n_o && !user_mode_o; endproperty
  property p_oe; flash_io_oe_o != 8'h00 |-> !flash_cs_n_o && flash_io_oe_o == 8'h01; endproperty
  property p_user; user_mode_o |-> !busy_o && !error_o; endproperty
  a_start: assert property (p_start) else $error("active load did not start");
  a_wide: assert property (p_wide) else $error("illegal width accepted");
  a_sec: assert property (p_sec) else $error("secured wide passive accepted");
  a_hold: assert property (p_hold) else $error("transfer while config reset low");
  a_gap: assert property (p_gap) else $error("fast read too soon after wake");
  a_auth: assert property (p_auth) else $error("auth failure not flagged");
  a_err: assert property (p_err) else $error("error with flash or user mode");
  a_oe: assert property (p_oe) else $error("flash drive outside frame");
  a_user: assert property (p_user) else $error("user mode while loading");
endmodule : cfl_loader_monitor
bind cfl_loader cfl_loader_monitor #(.WAKE_CYC(WAKE_CYC)) u_mon (.clk_sys_i, .reset_n_i, .config_reset_n_i,
  .mode_sel_i, .width_sel_i, .security_en_i, .auth_fail_i, .flash_cs_n_o, .flash_io_oe_o, .config_memory_cells_we_o,
  .busy_o, .user_mode_o, .error_o);

// [cfl_flash_model.sv]
// Behavioural serial flash: logs header bits, streams a byte count.
// Assumes the loader changes its output while the flash clock is low.
`timescale 1ns/1ns
module cfl_flash_model (
  input wire logic sclk_i, // Flash clock.
  input wire logic cs_n_i, // Select, active low.
  input wire logic si_i, // Serial data from loader.
  input wire logic addr4_i, // Four-byte addressing.
  output logic [7:0] io_o // Data lines to loader.
);
  logic [47:0] sh;
  logic [15:0] n, last_len;
  logic [7:0] k, last_byte;
  int frames = 0;
  initial io_o = 8'h5a;
  always @(negedge cs_n_i) begin
    n <= 16'h0000;
    k <= 8'h00;
  end
  always @(posedge sclk_i) begin
    if (!cs_n_i) begin
      if (n < 16'd48) sh <= {sh[46:0], si_i};
      n <= n + 16'h0001;
    end
  end
  // Data starts only after the full header, changing on the falling clock.
  always @(negedge sclk_i) begin
    if (!cs_n_i && n >= (addr4_i ? 16'd48 : 16'd40)) begin
      io_o <= k;
      k <= k + 8'h01;
    end
  end
  // Released lines flip so stale data never matches.
  always @(posedge cs_n_i) begin
    last_len <= n;
    last_byte <= sh[7:0];
    frames <= frames + 1;
    io_o <= ~io_o;
  end
endmodule : cfl_flash_model

// [cfl_loader_tb.sv]
// Self-checking bench for the configuration loader.
// Assumes cfl_pkg, cfl_loader, the checker and the flash model compile first.
`timescale 1ns/1ns
module cfl_loader_tb;
  import cfl_pkg::*;
  logic clk_sys_i, reset_n_i = 1'b0, cfg_n = 1'b0, a4 = 1'b0, ext_sel = 1'b0, ext_clk = 1'b0, sec = 1'b0;
  logic pclk = 1'b0, pcs_n = 1'b1, tck = 1'b0, tdi = 1'b0, auth = 1'b0, sclk, cs_n, we, busy, umode, err;
  logic [1:0] mode = MODE_ACTIVE;
  logic [2:0] wid = WID_X8;
  logic [7:0] fio_i, fio_o, oe;
  logic [15:0] pdat = 16'h0000, caddr, cdata;
  int miscompares = 0, n_compared = 0, cyc = 0;
  cfl_loader #(.WAKE_CYC(20)) dut (.clk_sys_i, .reset_n_i, .config_reset_n_i(cfg_n), .mode_sel_i(mode),
    .width_sel_i(wid), .addr4_i(a4), .clk_src_ext_i(ext_sel), .external_config_clock_pin_i(ext_clk),
    .flash_io_i(fio_i), .flash_sclk_o(sclk), .flash_cs_n_o(cs_n), .flash_io_o(fio_o), .flash_io_oe_o(oe),
    .pas_clk_i(pclk), .pas_cs_n_i(pcs_n), .pas_data_i(pdat), .jtag_tck_i(tck), .jtag_tdi_i(tdi),
    .security_en_i(sec), .auth_fail_i(auth), .config_memory_cells_we_o(we), .config_memory_cells_addr_o(caddr), .config_memory_cells_data_o(cdata),
    .busy_o(busy), .user_mode_o(umode), .error_o(err));
  cfl_flash_model fl (.sclk_i(sclk), .cs_n_i(cs_n), .si_i(fio_o[0]), .addr4_i(a4), .io_o(fio_i));
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  initial forever #16 ext_clk = ~ext_clk;
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      miscompares = miscompares + 1;
      wrap_up();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : tick
  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wrap_up();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  task automatic start(input logic [1:0] m, input logic [2:0] w, input logic s);
    cfg_n = 1'b0;
    mode = m;
    wid = w;
    sec = s;
    tick(8);
    chk("select in config reset", 48'h1, {47'h0, cs_n});
    chk("drive in config reset", 48'h0, {40'h0, oe});
    chk("busy in config reset", 48'h0, {47'h0, busy});
    cfg_n = 1'b1;
  endtask : start
  task automatic wait_we();
    for (int i = 0; i < 4000 && we !== 1'b1; i++) tick(1);
  endtask : wait_we
  task automatic run_active(input logic a, input logic e);
    int f0, nw;
    logic [47:0] hx, hg;
    a4 = a;
    ext_sel = e;
    f0 = fl.frames;
    start(MODE_ACTIVE, WID_X8, 1'b0);
    tick(4);
    chk("drive in wake", 48'h01, {40'h0, oe});
    chk("select in wake", 48'h0, {47'h0, cs_n});
    wait_we();
    chk("frames before data", 48'(f0 + 1), 48'(fl.frames));
    chk("wake byte", {40'h0, CMD_WAKE}, {40'h0, fl.last_byte});
    chk("wake bits", 48'h8, {32'h0, fl.last_len});
    chk("first word", 48'h0001, {32'h0, cdata});
    chk("first address", 48'h0, {32'h0, caddr});
    chk("busy in load", 48'h1, {47'h0, busy});
    chk("drive in data phase", 48'h0, {40'h0, oe});
    nw = 0;
    for (int i = 0; i < 40000 && umode !== 1'b1; i++) begin
      nw += (we === 1'b1);
      tick(1);
    end
    // The closing word strobe stands in the same cycle that user mode rises.
    nw += (we === 1'b1);
    hx = a ? {CMD_FAST_READ, START_ADDR, DUMMY_BYTE} : {8'h00, CMD_FAST_READ, START_ADDR[23:0], DUMMY_BYTE};
    hg = a ? fl.sh : {8'h00, fl.sh[47:8]};
    chk("read header", hx, hg);
    chk("word count", 48'(LOAD_WORDS), 48'(nw));
    chk("last word", 48'hfeff, {32'h0, cdata});
    chk("busy after load", 48'h0, {47'h0, busy});
  endtask : run_active
  task automatic refusals();
    logic [5:0] tbl [4] = '{6'h04, 6'h05, 6'h0d, 6'h2c};
    for (int i = 0; i < 4; i++) begin
      start(tbl[i][4:3], tbl[i][2:0], tbl[i][5]);
      tick(20);
      chk("refused error", 48'h1, {47'h0, err});
      chk("refused select", 48'h1, {47'h0, cs_n});
    end
  endtask : refusals
  task automatic abort();
    a4 = 1'b0;
    ext_sel = 1'b0;
    start(MODE_ACTIVE, WID_X8, 1'b0);
    wait_we();
    auth = 1'b1;
    tick(1);
    auth = 1'b0;
    tick(20);
    chk("abort error", 48'h1, {47'h0, err});
    chk("abort user mode", 48'h0, {47'h0, umode});
  endtask : abort
  task automatic run_passive();
    start(MODE_PASSIVE, WID_X16, 1'b0);
    tick(8000);
    pcs_n = 1'b0;
    // master drives clock, select and data
    for (int j = 0; j < LOAD_WORDS; j++) begin
      pdat = 16'(j * 3);
      tick(2);
      pclk = 1'b1;
      tick(2);
      pclk = 1'b0;
    end
    pcs_n = 1'b1;
    tick(10);
    chk("passive user mode", 48'h1, {47'h0, umode});
    chk("passive last word", 48'h0bfd, {32'h0, cdata});
    chk("passive select", 48'h1, {47'h0, cs_n});
  endtask : run_passive
  task automatic run_jtag(input logic [1:0] m);
    start(m, 3'h5, 1'b0);
    tick(10);
    for (int j = 15; j >= 0; j--) begin
      tdi = 1'(16'hc3a5 >> j);
      tick(2);
      tck = 1'b1;
      tick(2);
      tck = 1'b0;
    end
    tick(10);
    chk("scan word", 48'hc3a5, {32'h0, cdata});
    chk("scan error", 48'h0, {47'h0, err});
  endtask : run_jtag
  initial begin
    tick(12);
    reset_n_i = 1'b1;
    tick(3);
    run_active(1'b0, 1'b0);
    refusals();
    abort();
    run_active(1'b1, 1'b1);
    run_passive();
    run_jtag(MODE_JTAG);
    run_jtag(2'h3);
    wrap_up();
  end
endmodule : cfl_loader_tb
